/* rtl/adcs_pkg.sv */
// shared constants, encodings and types of the conversion sequencer
package adcs_pkg;

   // register map, byte offsets of 32-bit words
   localparam logic [3:0] REG_CFG_OFS  = 4'h0;
   localparam logic [3:0] REG_RES_OFS  = 4'h4;
   localparam logic [3:0] REG_STAT_OFS = 4'h8;

   // configuration word field positions
   localparam int CFG_MUX_LSB   = 0;
   localparam int CFG_RANGE_LSB = 3;
   localparam int CFG_RATE_LSB  = 6;
   localparam int CFG_MODE_BIT  = 9;
   localparam int CFG_TRIG_BIT  = 10;

   // status word bit positions
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_POWER_BIT = 1;
   localparam int STAT_VALID_BIT = 2;

   // reset values: 2.048 V span, slowest rate, single-shot
   localparam logic [2:0] MUX_RST   = 3'h0;
   localparam logic [2:0] RANGE_RST = 3'h2;
   localparam logic [2:0] RATE_RST  = 3'h0;
   localparam logic       MODE_RST  = 1'b1;

   // input select codes, pairs first, then singles against ground
   localparam logic [2:0] MUX_P0_N1 = 3'h0;
   localparam logic [2:0] MUX_P2_N3 = 3'h1;
   localparam logic [2:0] MUX_P0_N3 = 3'h2;
   localparam logic [2:0] MUX_P1_N3 = 3'h3;

   // widths
   localparam int SAMPLE_W = 24;   // front-end value, one unit = 7.8125 uV
   localparam int CODE_W   = 16;
   localparam int PERIOD_W = 24;

   // internal oscillator rate in Hz
   localparam int unsigned OSC_HZ_DEF = 100_000_000;

   // output data rates in samples per second, by rate code
   localparam int unsigned RATE_SPS [8] = '{64, 128, 256, 512, 1024, 2000, 4000, 8000};

   // code step per range code in front-end units (6.144 V down to 0.256 V)
   localparam int unsigned RANGE_STEP [8] = '{24, 16, 8, 4, 2, 1, 1, 1};

   typedef enum logic [2:0] {
      RATE_64, RATE_128, RATE_256, RATE_512, RATE_1K, RATE_2K, RATE_4K, RATE_8K
   } adcs_rate_t;

   typedef struct packed {
      logic       mode;
      logic [2:0] rate;
      logic [2:0] range;
      logic [2:0] mux;
   } adcs_cfg_t;

endpackage : adcs_pkg

/* rtl/adcs_code_path.sv */
// input capture, selection, scaling and saturation of one result code
`timescale 1ns/1ps
module adcs_code_path
   import adcs_pkg::*;
(
   // clock and reset
   input  wire logic                            ref_clk,
   input  wire logic                            rstn,
   // front-end values, one per analog input
   input  wire logic [3:0][SAMPLE_W-1:0]        analogIn,
   // selection from the sequencer
   input  wire logic [2:0]                      muxSel,
   input  wire logic [2:0]                      rangeSel,
   // registered code
   output logic signed [CODE_W-1:0]             codeOut_r,
   output logic                                 singleEnded_r
);

   logic [3:0][SAMPLE_W-1:0] sync1_r, sync2_r, sync3_r, held_r;
   logic signed [SAMPLE_W:0] posVal, negVal, diff, scaled;
   logic signed [CODE_W-1:0] codeNxt;

   // three-stage capture per input; a value counts once stages two and three agree
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_cap
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               sync1_r[ch] <= '0;
               sync2_r[ch] <= '0;
               sync3_r[ch] <= '0;
               held_r[ch]  <= '0;
            end else begin
               sync1_r[ch] <= analogIn[ch];
               sync2_r[ch] <= sync1_r[ch];
               sync3_r[ch] <= sync2_r[ch];
               if (sync2_r[ch] == sync3_r[ch]) held_r[ch] <= sync3_r[ch];
            end
         end
      end
   endgenerate

   // input routing and signed scaling; the divide trades area for exact steps
   always_comb begin
      negVal = '0;
      case (muxSel)
         MUX_P0_N1: begin
            posVal = $signed({held_r[0][SAMPLE_W-1], held_r[0]});
            negVal = $signed({held_r[1][SAMPLE_W-1], held_r[1]});
         end
         MUX_P2_N3: begin
            posVal = $signed({held_r[2][SAMPLE_W-1], held_r[2]});
            negVal = $signed({held_r[3][SAMPLE_W-1], held_r[3]});
         end
         MUX_P0_N3: begin
            posVal = $signed({held_r[0][SAMPLE_W-1], held_r[0]});
            negVal = $signed({held_r[3][SAMPLE_W-1], held_r[3]});
         end
         MUX_P1_N3: begin
            posVal = $signed({held_r[1][SAMPLE_W-1], held_r[1]});
            negVal = $signed({held_r[3][SAMPLE_W-1], held_r[3]});
         end
         default: begin                               // negative side grounded
            posVal = $signed({held_r[muxSel[1:0]][SAMPLE_W-1], held_r[muxSel[1:0]]});
         end
      endcase
      diff = posVal - negVal;
      if (muxSel[2] && diff < 0) diff = '0;
      scaled = diff / $signed((SAMPLE_W+1)'(RANGE_STEP[rangeSel]));
      if (scaled > $signed((SAMPLE_W+1)'(16'sh7fff)))
         codeNxt = 16'sh7fff;
      else if (scaled < $signed({{(SAMPLE_W-CODE_W+1){1'b1}}, 16'h8000}))
         codeNxt = 16'sh8000;
      else
         codeNxt = scaled[CODE_W-1:0];
   end

   // registered code
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         codeOut_r     <= '0;
         singleEnded_r <= 1'b0;
      end else begin
         codeOut_r     <= codeNxt;
         singleEnded_r <= muxSel[2];
      end
   end

   chk_sign_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
      codeOut_r < 0 |-> $past(diff) < 0) else $error("negative code without negative difference");

endmodule : adcs_code_path

/* rtl/adcs_sequencer.sv */
// conversion sequencer with its AHB-Lite register slave
`timescale 1ns/1ps
module adcs_sequencer
   import adcs_pkg::*;
#(
   parameter int unsigned OSC_HZ = OSC_HZ_DEF
)(
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rstn,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic [31:0]                   hrdata,
   // front-end values, one per analog input
   input  wire logic [3:0][SAMPLE_W-1:0] analogIn,
   // analog control and the conversion done pulse
   output logic                          modulatorOn,
   output logic [1:0]                    positiveInput,
   output logic [1:0]                    negativeInput,
   output logic                          negInputGrounded,
   output logic [2:0]                    rangeSelect,
   output logic                          convDone
);

   typedef enum logic {ST_DOWN, ST_CONV} adcs_state_t;

   adcs_state_t               state_r;
   adcs_cfg_t                 cfg_r, cfgNxt, convCfg_r;
   logic [PERIOD_W-1:0]       cnt_r, periodNxt;
   logic                      wrPend_r, cfgWr, trigReq, startConv, endConv;
   logic [3:0]                wrOfs_r;
   logic signed [CODE_W-1:0]  result_r, pathCode;
   logic                      resultValid_r, resultSingle_r, pathSingle;
   logic                      hreadyout_r, hresp_r, done_r, grounded_r;
   logic [31:0]               hrdata_r;
   logic [1:0]                posSel_r, negSel_r;
   logic [PERIOD_W-1:0]       convLen_r;

   // periods are oscillator cycles per output sample, so rates track the oscillator
   function automatic logic [PERIOD_W-1:0] period_of(input logic [2:0] rate);
      period_of = PERIOD_W'(OSC_HZ / RATE_SPS[rate]);
   endfunction

   // ------------------------------------------------------------------
   // bus slave: zero wait states, every access answered OKAY
   // ------------------------------------------------------------------

   // address phase capture for the following write data phase
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wrPend_r <= 1'b0;
         wrOfs_r  <= '0;
      end else if (hready) begin
         wrPend_r <= hsel && htrans[1] && hwrite;
         wrOfs_r  <= haddr[3:0];
      end
   end

   // read data is fetched at the address phase edge and stands for the data phase
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hrdata_r <= '0;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[3:0])
            REG_CFG_OFS:  hrdata_r <= 32'(cfg_r);   // trigger bit always reads 0
            REG_RES_OFS:  hrdata_r <= {16'h0000, result_r};
            REG_STAT_OFS: hrdata_r <= 32'({resultValid_r, state_r == ST_CONV,
                                          state_r == ST_CONV});
            default:      hrdata_r <= '0;
         endcase
      end
   end

   // handshake outputs held as flops so they are defined straight out of reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end
   end

   assign cfgWr   = wrPend_r && (wrOfs_r == REG_CFG_OFS);
   assign trigReq = cfgWr && hwdata[CFG_TRIG_BIT];

   // configuration as it stands after this cycle's write, if any
   always_comb begin
      cfgNxt = cfg_r;
      if (cfgWr) begin
         cfgNxt.mux   = hwdata[CFG_MUX_LSB +: 3];
         cfgNxt.range = hwdata[CFG_RANGE_LSB +: 3];
         cfgNxt.rate  = hwdata[CFG_RATE_LSB +: 3];
         cfgNxt.mode  = hwdata[CFG_MODE_BIT];
      end
   end

   // configuration register; the trigger bit is never stored
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_r <= '{mode: MODE_RST, rate: RATE_RST, range: RANGE_RST, mux: MUX_RST};
      end else begin
         cfg_r <= cfgNxt;
      end
   end

   // ------------------------------------------------------------------
   // conversion sequencing
   // ------------------------------------------------------------------

   // a trigger only counts in single-shot mode with the converter idle
   assign startConv = (state_r == ST_DOWN) &&
                      ((cfgNxt.mode && trigReq) || !cfgNxt.mode);
   assign endConv   = (state_r == ST_CONV) && (cnt_r == '0);
   assign periodNxt = period_of(cfgNxt.rate) - PERIOD_W'(1);

   // state and period counter; settings are latched so a write cannot bend a sample
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r   <= ST_DOWN;
         cnt_r     <= '0;
         convCfg_r <= '{mode: MODE_RST, rate: RATE_RST, range: RANGE_RST, mux: MUX_RST};
      end else begin
         case (state_r)
            ST_DOWN: begin
               if (startConv) begin
                  state_r   <= ST_CONV;
                  cnt_r     <= periodNxt;
                  convCfg_r <= cfgNxt;
               end
            end
            ST_CONV: begin
               if (!endConv) begin
                  cnt_r <= cnt_r - PERIOD_W'(1);
               end else if (!cfgNxt.mode) begin      // back to back
                  cnt_r     <= periodNxt;
                  convCfg_r <= cfgNxt;
               end else begin
                  state_r <= ST_DOWN;                 // power down
               end
            end
            default: begin
               state_r <= ST_DOWN;
            end
         endcase
      end
   end

   // result capture at the end of each conversion; the newest always wins
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         result_r       <= '0;
         resultValid_r  <= 1'b0;
         resultSingle_r <= 1'b0;
         done_r         <= 1'b0;
      end else begin
         done_r <= endConv;
         if (endConv) begin
            result_r       <= pathCode;
            resultValid_r  <= 1'b1;
            resultSingle_r <= pathSingle;
         end
      end
   end

   // analog control follows the latched settings
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         posSel_r   <= 2'h0;
         negSel_r   <= 2'h1;
         grounded_r <= 1'b0;
      end else begin
         grounded_r <= convCfg_r.mux[2];
         case (convCfg_r.mux)
            MUX_P0_N1: begin posSel_r <= 2'h0; negSel_r <= 2'h1; end
            MUX_P2_N3: begin posSel_r <= 2'h2; negSel_r <= 2'h3; end
            MUX_P0_N3: begin posSel_r <= 2'h0; negSel_r <= 2'h3; end
            MUX_P1_N3: begin posSel_r <= 2'h1; negSel_r <= 2'h3; end
            default:   begin posSel_r <= convCfg_r.mux[1:0]; negSel_r <= 2'h0; end
         endcase
      end
   end

   // selection, scaling and saturation of the code
   adcs_code_path u_code_path (
      .ref_clk       (ref_clk),
      .rstn          (rstn),
      .analogIn      (analogIn),
      .muxSel        (convCfg_r.mux),
      .rangeSel      (convCfg_r.range),
      .codeOut_r     (pathCode),
      .singleEnded_r (pathSingle)
   );

   // every port is a flop
   assign hreadyout        = hreadyout_r;
   assign hresp            = hresp_r;
   assign hrdata           = hrdata_r;
   assign modulatorOn      = (state_r == ST_CONV);
   assign positiveInput    = posSel_r;
   assign negativeInput    = negSel_r;
   assign negInputGrounded = grounded_r;
   assign rangeSelect      = convCfg_r.range;
   assign convDone         = done_r;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------

   // cycles since the current conversion began, for length checks
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         convLen_r <= '0;
      end else if (state_r == ST_DOWN && !startConv) begin
         convLen_r <= '0;
      end else if ((state_r == ST_DOWN) || endConv) begin
         convLen_r <= PERIOD_W'(1);
      end else begin
         convLen_r <= convLen_r + PERIOD_W'(1);
      end
   end

   chk_conv_length: assert property (@(posedge ref_clk) disable iff (!rstn)
      endConv |-> convLen_r == period_of(convCfg_r.rate))
      else $error("conversion length differs from one over the rate");

   chk_oneshot_down: assert property (@(posedge ref_clk) disable iff (!rstn)
      endConv && cfgNxt.mode |=> state_r == ST_DOWN ##1 (state_r == ST_DOWN || $past(trigReq)))
      else $error("single-shot did not power down after one conversion");

   chk_cont_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
      endConv && !cfgNxt.mode |=> state_r == ST_CONV && convLen_r == PERIOD_W'(1))
      else $error("continuous mode did not restart at once");

   chk_trig_start: assert property (@(posedge ref_clk) disable iff (!rstn)
      trigReq && hwdata[CFG_MODE_BIT] && state_r == ST_DOWN |=> modulatorOn && cfg_r.mode)
      else $error("trigger did not start a conversion");

   chk_trig_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
      trigReq && state_r == ST_CONV && !endConv |=> convLen_r == $past(convLen_r) + PERIOD_W'(1))
      else $error("trigger restarted a running conversion");

   chk_idle_stays: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_r == ST_DOWN && cfg_r.mode && !cfgWr |=> state_r == ST_DOWN)
      else $error("conversion began without a request");

   chk_single_nonneg: assert property (@(posedge ref_clk) disable iff (!rstn)
      resultValid_r && resultSingle_r |-> result_r >= 0)
      else $error("single-ended result is negative");

   chk_ground_switch: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_r == ST_CONV && $stable(convCfg_r.mux) ##1 $stable(convCfg_r.mux)
      |-> negInputGrounded == convCfg_r.mux[2])
      else $error("ground switch disagrees with input selection");

   chk_bus_okay: assert property (@(posedge ref_clk) disable iff (!rstn)
      hsel && htrans[1] |=> hreadyout && !hresp)
      else $error("bus access not answered OKAY at once");

   cov_oneshot: cover property (@(posedge ref_clk) disable iff (!rstn)
      trigReq && state_r == ST_DOWN ##1 state_r == ST_CONV);
   cov_continuous: cover property (@(posedge ref_clk) disable iff (!rstn)
      endConv && !cfgNxt.mode);
   cov_trig_busy: cover property (@(posedge ref_clk) disable iff (!rstn)
      trigReq && state_r == ST_CONV);

endmodule : adcs_sequencer

/* test/adcs_host_model.sv */
// AHB-Lite host model that configures and reads the conversion sequencer
`timescale 1ns/1ps
module adcs_host_model
   import adcs_pkg::*;
(
   // clock
   input  wire logic        ref_clk,
   // AHB-Lite master side
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   // quiet bus from time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'b010;
      hwdata = 32'h0000_0000;
   end

   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic wr, input logic [31:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= adr;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      // released address lines change so a stale value never looks valid
      hsel   <= 1'b0;
      htrans <= 2'b00;
      haddr  <= ~adr;
      hwdata <= wr ? wd : ~wd;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask

   // configuration word: mode one is single-shot, trigger starts one shot
   task automatic set_cfg(input logic [2:0] mux, input logic [2:0] rng, input logic [2:0] rate,
                          input logic mode, input logic trig);
      logic [31:0] w;
      logic [31:0] unused;
      w = 32'h0000_0000;
      w[CFG_MUX_LSB +: 3]   = mux;
      w[CFG_RANGE_LSB +: 3] = rng;
      w[CFG_RATE_LSB +: 3]  = rate;
      w[CFG_MODE_BIT]       = mode;
      w[CFG_TRIG_BIT]       = trig;
      xfer(1'b1, {28'h000_0000, REG_CFG_OFS}, w, unused);
   endtask
endmodule // adcs_host_model

/* test/testbench.sv */
// self-checking bench for the conversion sequencer against a behavioural model
`timescale 1ns/1ps
module testbench;
   import adcs_pkg::*;
   localparam int unsigned OSC_SIM = 64000;
   logic                     ref_clk = 1'b0;
   logic                     rstn = 1'b0;
   logic                     hsel, hwrite, hreadyout, hresp, modulatorOn;
   logic                     negInputGrounded, convDone;
   logic [31:0]              haddr, hwdata, hrdata, readWord;
   logic [1:0]               htrans, positiveInput, negativeInput;
   logic [2:0]               hsize, rangeSelect;
   logic [3:0][SAMPLE_W-1:0] analogIn = '0;
   int                       fail_count = 0;
   int                       comparisons = 0;
   int                       onRun = 0;
   int                       lastRun = 0;
   int                       donePulses = 0;
   int                       d0 = 0;

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   adcs_sequencer #(.OSC_HZ(OSC_SIM)) i_adcs_sequencer (
      .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analogIn(analogIn),
      .modulatorOn(modulatorOn), .positiveInput(positiveInput),
      .negativeInput(negativeInput), .negInputGrounded(negInputGrounded),
      .rangeSelect(rangeSelect), .convDone(convDone));

   adcs_host_model i_adcs_host_model (
      .ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

   // length of the last powered run and count of finished results
   always @(posedge ref_clk) begin
      if (modulatorOn === 1'b1) onRun <= onRun + 1;
      else begin
         if (onRun != 0) lastRun <= onRun;
         onRun <= 0;
      end
      if (convDone === 1'b1) donePulses <= donePulses + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (fail_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic rd_reg(input logic [3:0] ofs, output logic [31:0] v);
      i_adcs_host_model.xfer(1'b0, {28'h000_0000, ofs}, 32'h0000_0000, v);
   endtask

   // model of the input pairing: pairs first, then singles against ground
   function automatic int pos_of(input logic [2:0] m);
      return (m >= 3'h4) ? int'(m) - 4 : (m == MUX_P2_N3) ? 2 : (m == MUX_P1_N3) ? 1 : 0;
   endfunction
   function automatic int neg_of(input logic [2:0] m);
      return (m == MUX_P0_N1) ? 1 : 3;
   endfunction

   // expected code: difference over step, truncated and saturated
   function automatic logic [31:0] model_code(input logic [2:0] m, input logic [2:0] rng);
      int d;
      int c;
      d = $signed(analogIn[pos_of(m)]);
      if (m < 3'h4) d = d - $signed(analogIn[neg_of(m)]);
      c = d / int'(RANGE_STEP[rng]);
      if (c > 32767) c = 32767;
      if (c < -32768) c = -32768;
      if (m >= 3'h4 && c < 0) c = 0;
      return {16'h0000, c[15:0]};
   endfunction

   // bounded wait for the result pulse
   task automatic wait_done();
      int n;
      n = 0;
      while (convDone !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      check(32'(n < 3000), 1, "completion");
      // let the run-length and pulse counters settle past the pulse edge
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic run_single(input logic [2:0] rate, input logic [2:0] m, input logic [2:0] rng);
      logic [31:0] v;
      for (int i = 0; i < 4; i++) analogIn[i] <= SAMPLE_W'($urandom);
      repeat (6) @(posedge ref_clk);
      d0 = donePulses;
      i_adcs_host_model.set_cfg(m, rng, rate, 1'b1, 1'b1);
      wait_done();
      check(32'(lastRun), OSC_SIM / RATE_SPS[rate], "length");
      check(32'(donePulses - d0), 1, "one result");
      check(32'(rangeSelect), 32'(rng), "range");
      check(32'(positiveInput), pos_of(m), "positive input");
      check(32'(negInputGrounded), 32'(m >= 3'h4), "ground switch");
      if (m < 3'h4) check(32'(negativeInput), neg_of(m), "negative input");
      rd_reg(REG_RES_OFS, v);
      check(v, model_code(m, rng), "code");
      rd_reg(REG_STAT_OFS, v);
      check(v, 32'h0000_0004, "status after shot");
      rd_reg(REG_CFG_OFS, v);
      check(v, {22'h00_0000, 1'b1, rate, rng, m}, "config");
   endtask

   // hang guard, well beyond the expected run
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      finish_test();
   end

   // main sequence
   initial begin
      void'($urandom(26));
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      check(32'({modulatorOn, hresp, rangeSelect}), 32'h0000_0002, "reset pins");
      rd_reg(REG_STAT_OFS, readWord);
      check(readWord, 32'h0000_0000, "status reset");
      i_adcs_host_model.xfer(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, readWord);
      rd_reg(4'hC, readWord);
      check(readWord, 32'h0000_0000, "unmapped word");
      rd_reg(REG_CFG_OFS, readWord);
      check(readWord, 32'h0000_0210, "config reset");
      // every rate and input code, twice over with the same pairings
      for (int t = 0; t < 16; t++) run_single(3'(t), 3'(t * 3), 3'($urandom));
      // a second trigger in mid-conversion leaves no trace
      d0 = donePulses;
      i_adcs_host_model.set_cfg(MUX_P0_N1, 3'h2, 3'h0, 1'b1, 1'b1);
      repeat (100) @(posedge ref_clk);
      i_adcs_host_model.set_cfg(MUX_P0_N1, 3'h2, 3'h0, 1'b1, 1'b1);
      wait_done();
      repeat (20) @(posedge ref_clk);
      check(32'(lastRun), OSC_SIM / RATE_SPS[0], "ignored trigger");
      check(32'(donePulses - d0), 1, "ignored trigger count");
      check(32'(modulatorOn), 0, "powered down");
      // continuous mode at the fastest rate, then back to single-shot
      for (int i = 0; i < 4; i++) analogIn[i] <= SAMPLE_W'($urandom);
      d0 = donePulses;
      i_adcs_host_model.set_cfg(3'h4, 3'h5, 3'h7, 1'b0, 1'b0);
      repeat (100) @(posedge ref_clk);
      check(32'((donePulses - d0) inside {[10:12]}), 1, "back to back");
      rd_reg(REG_RES_OFS, readWord);
      check(readWord, model_code(3'h4, 3'h5), "newest result");
      i_adcs_host_model.set_cfg(3'h4, 3'h5, 3'h7, 1'b1, 1'b0);
      repeat (20) @(posedge ref_clk);
      d0 = donePulses;
      repeat (20) @(posedge ref_clk);
      check(32'(donePulses - d0), 0, "stopped");
      check(32'(modulatorOn), 0, "stopped power");
      // reset in mid-conversion restores defaults
      i_adcs_host_model.set_cfg(3'h1, 3'h0, 3'h0, 1'b1, 1'b1);
      repeat (50) @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      check(32'(modulatorOn), 0, "reset power");
      rd_reg(REG_CFG_OFS, readWord);
      check(readWord, 32'h0000_0210, "config second reset");
      finish_test();
   end
endmodule // testbench
